// ===== utde_tx.sv
// serial transmitter with transceiver drive gate and interrupt split
`timescale 1ns/100ps
module utde_tx
  import utde_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire utde_cfg_s CFG,
  input wire logic [15:0] BAUD_DIV,
  input wire logic [UTDE_DATA_W-1:0] TX_DATA,
  input wire logic TX_WRITE,
  output logic TX_READY,
  input wire logic RX_EVENT,
  output logic TXD,
  output logic TRANSCEIVER_DRIVE_GATE,
  output utde_irq_s IRQ
);
  typedef struct packed {
    utde_state_e state;
    logic [15:0] baud_cnt;
    logic [3:0] bit_idx;
    logic [UTDE_DATA_W-1:0] shift;
    logic parity;
    logic txd;
    logic gate;
    logic tx_irq;
    logic rx_irq;
    logic timer_irq;
  } utde_tx_s;
  utde_tx_s st_q, st_d;
  logic [UTDE_DATA_W-1:0] f_data;
  logic f_valid, f_pop, tick, rx_s1_q, rx_s2_q;

  // rule fifo holds written bytes; pop when a new frame is launched
  utde_fifo #(.WIDTH(UTDE_DATA_W), .DEPTH(UTDE_FIFO_DEPTH)) u_fifo (
    .CLK(CLK),
    .RESET(RESET),
    .in_data(TX_DATA),
    .in_valid(TX_WRITE),
    .in_ready(TX_READY),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  // receive event is external, synchronise it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
    end else begin
      rx_s1_q <= RX_EVENT;
      rx_s2_q <= rx_s1_q;
    end
  end

  assign tick = (st_q.baud_cnt == 16'h0000);
  assign f_pop = CFG.enable && f_valid &&
    ((st_q.state == UTDE_IDLE) || (st_q.state == UTDE_TAIL)
     || (st_q.state == UTDE_STOP && tick && st_q.bit_idx == 4'h0));

  // frame sequencer
  always_comb begin
    st_d = st_q;
    st_d.tx_irq = 1'b0;
    st_d.rx_irq = 1'b0;
    st_d.timer_irq = 1'b0;
    st_d.baud_cnt = tick ? BAUD_DIV : st_q.baud_cnt - 16'h0001;
    case (st_q.state)
      UTDE_IDLE: begin
        st_d.txd = 1'b1;
        if (f_pop) begin
          st_d.state = UTDE_LEAD;
          st_d.shift = f_data;
          st_d.gate = 1'b1;
          st_d.baud_cnt = BAUD_DIV;
          st_d.bit_idx = UTDE_LEAD_BITS - 4'h1;
        end
      end
      UTDE_LEAD: begin
        if (tick) begin
          st_d.state = UTDE_START;
          st_d.txd = 1'b0;
          st_d.parity = CFG.parity_odd;
        end
      end
      UTDE_START: begin
        if (tick) begin
          st_d.state = UTDE_DATA;
          st_d.txd = st_q.shift[0];
          st_d.parity = st_q.parity ^ st_q.shift[0];
          st_d.bit_idx = 4'h0;
        end
      end
      UTDE_DATA: begin
        if (tick) begin
          if (st_q.bit_idx == UTDE_LAST_DATA) begin
            st_d.state = CFG.parity_en ? UTDE_PAR : UTDE_STOP;
            st_d.txd = CFG.parity_en ? st_q.parity : 1'b1;
            st_d.bit_idx = {3'h0, CFG.two_stop};
          end else begin
            st_d.shift = st_q.shift >> 1;
            st_d.txd = st_q.shift[1];
            st_d.parity = st_q.parity ^ st_q.shift[1];
            st_d.bit_idx = st_q.bit_idx + 4'h1;
          end
        end
      end
      UTDE_PAR: begin
        if (tick) begin
          st_d.state = UTDE_STOP;
          st_d.txd = 1'b1;
        end
      end
      UTDE_STOP: begin
        if (tick) begin
          if (st_q.bit_idx != 4'h0) begin
            st_d.bit_idx = st_q.bit_idx - 4'h1;
          end else begin
            st_d.tx_irq = 1'b1;
            if (f_pop) begin
              st_d.state = UTDE_START;
              st_d.shift = f_data;
              st_d.txd = 1'b0;
              st_d.parity = CFG.parity_odd;
            end else begin
              st_d.state = UTDE_TAIL;
            end
          end
        end
      end
      UTDE_TAIL: begin
        if (f_pop) begin
          st_d.state = UTDE_START;
          st_d.shift = f_data;
          st_d.txd = 1'b0;
          st_d.parity = CFG.parity_odd;
          st_d.baud_cnt = BAUD_DIV;
        end else begin
          st_d.state = UTDE_IDLE;
          st_d.gate = 1'b0;
        end
      end
      default: begin
        st_d.state = UTDE_IDLE;
        st_d.gate = 1'b0;
        st_d.txd = 1'b1;
      end
    endcase
    if (!CFG.enable) begin
      st_d.state = UTDE_IDLE;
      st_d.gate = 1'b0;
      st_d.txd = 1'b1;
      st_d.timer_irq = tick;
      // no transmit request once the unit is switched off mid-stop
      st_d.tx_irq = 1'b0;
    end
    st_d.rx_irq = CFG.enable && rx_s2_q;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_q <= '0;
      st_q.state <= UTDE_IDLE;
      st_q.txd <= 1'b1;
      st_q.baud_cnt <= UTDE_DIV_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign TRANSCEIVER_DRIVE_GATE = st_q.gate ^ CFG.driver_enable_polarity;
  assign TXD = st_q.txd;
  assign IRQ = '{tx_irq: st_q.tx_irq, rx_irq: st_q.rx_irq, timer_irq: st_q.timer_irq};

  // gate drops one clock after stop
  a_gate_release: assert property (@(posedge CLK) disable iff (RESET)
    (st_q.state == UTDE_TAIL && !f_valid) |=> !st_q.gate)
    else $error("gate not released after tail");
  a_gate_frame: assert property (@(posedge CLK) disable iff (RESET)
    (st_q.state inside {UTDE_START, UTDE_DATA, UTDE_PAR, UTDE_STOP}) |-> st_q.gate)
    else $error("gate low during frame");
  sequence s_launch;
    st_q.state == UTDE_IDLE ##1 st_q.state == UTDE_LEAD;
  endsequence
  a_gate_lead: assert property (@(posedge CLK) disable iff (RESET)
    s_launch |-> st_q.gate && st_q.txd)
    else $error("lead without gate");
  a_idle_off: assert property (@(posedge CLK) disable iff (RESET)
    (st_q.state == UTDE_IDLE) |-> !st_q.gate)
    else $error("gate on in idle");
  // pin level from state and polarity
  a_pol_pin: assert property (@(posedge CLK) disable iff (RESET)
    TRANSCEIVER_DRIVE_GATE == (CFG.driver_enable_polarity ^ (st_q.state != UTDE_IDLE)))
    else $error("pin level does not follow polarity");
  a_b2b_hold: assert property (@(posedge CLK) disable iff (RESET)
    (st_q.state == UTDE_STOP && f_pop) |=> st_q.gate && st_q.state == UTDE_START)
    else $error("gate dropped between bytes");
  a_write_gate: assert property (@(posedge CLK) disable iff (RESET)
    (st_q.state == UTDE_IDLE && CFG.enable && f_valid) |=> st_q.gate)
    else $error("write did not raise gate");
  a_timer_mode: assert property (@(posedge CLK) disable iff (RESET)
    (!CFG.enable && tick) |=> st_q.timer_irq && !st_q.tx_irq)
    else $error("timer interrupt missing");
endmodule

// ===== utde_pkg.sv
// package for the serial transmitter with transceiver drive gate
package utde_pkg;
  localparam int unsigned UTDE_DATA_W = 8;
  localparam int unsigned UTDE_FIFO_DEPTH = 4;
  localparam logic [15:0] UTDE_DIV_RESET = 16'h0001;
  localparam logic [3:0] UTDE_LEAD_BITS = 4'h1;
  localparam logic [3:0] UTDE_LAST_DATA = 4'h7;

  typedef enum logic [2:0] {
    UTDE_IDLE, UTDE_LEAD, UTDE_START, UTDE_DATA, UTDE_PAR, UTDE_STOP, UTDE_TAIL
  } utde_state_e;

  typedef struct packed {
    logic enable;
    logic parity_en;
    logic parity_odd;
    logic two_stop;
    logic driver_enable_polarity;
  } utde_cfg_s;

  typedef struct packed {
    logic tx_irq;
    logic rx_irq;
    logic timer_irq;
  } utde_irq_s;
endpackage

// ===== utde_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module utde_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } utde_fifo_s;
  utde_fifo_s st_q, st_d;
  logic push, pop;

  // handshakes from the fill count
  assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign out_data = st_q.mem[st_q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and storage update
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr = (st_q.wr == AW'(DEPTH-1)) ? '0 : st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = (st_q.rd == AW'(DEPTH-1)) ? '0 : st_q.rd + 1'b1;
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ===== utde_line_model.sv
// line transceiver model: drives the bus while gated on and decodes frames
`timescale 1ns/100ps
module utde_line_model
  import utde_pkg::*;
(
  input wire logic clk,
  input wire utde_cfg_s cfg,
  input wire logic [15:0] baud_div,
  input wire logic txd,
  input wire logic transceiver_drive_gate,
  output logic bus,
  output logic [7:0] rx_byte,
  output logic rx_bad,
  output int lead,
  output logic end_act,
  output logic rel_act,
  output int frames
);
  logic act;
  assign act = transceiver_drive_gate ^ cfg.driver_enable_polarity;
  // released bus is biased high, like a failsafe line
  assign bus = act ? txd : 1'b1;
  // counts gated idle clocks, then samples each bit at its middle
  initial begin
    int bitc;
    int lead_q;
    logic again;
    logic bad;
    logic [7:0] b;
    frames = 0;
    lead_q = 0;
    again = 0;
    forever begin
      if (!again) @(negedge clk);
      again = 0;
      if (!(act && !bus)) begin
        lead_q = act ? lead_q + 1 : 0;
        continue;
      end
      bitc = int'(baud_div) + 1;
      lead = lead_q;
      lead_q = 0;
      bad = 0;
      repeat (bitc / 2) @(negedge clk);
      if (bus) bad = 1;
      for (int i = 0; i < 8; i++) begin
        repeat (bitc) @(negedge clk);
        b[i] = bus;
      end
      if (cfg.parity_en) begin
        repeat (bitc) @(negedge clk);
        if (bus !== (^b ^ cfg.parity_odd)) bad = 1;
      end
      repeat (cfg.two_stop ? 2 : 1) begin
        repeat (bitc) @(negedge clk);
        if (!bus) bad = 1;
      end
      repeat (bitc - bitc / 2) @(negedge clk);
      end_act = act;
      rel_act = act;
      if (bus) begin
        @(negedge clk);
        rel_act = act;
      end else again = 1;
      rx_byte = b;
      rx_bad = bad;
      frames++;
    end
  end
endmodule

// ===== uart_transceiver_driver_enable_bench.sv
// bench for the transmitter gate, its fifo and the interrupt split
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); end end
module uart_transceiver_driver_enable_bench;
  import utde_pkg::*;
  typedef struct packed {logic [7:0] data; utde_cfg_s cfg;} utde_row_s;
  logic clk, reset = 1, tx_write = 0, rx_event = 0, tx_ready, txd, gate, bus;
  logic rx_bad, end_act, rel_act;
  logic [7:0] tx_data = 8'h00, rx_byte;
  logic [15:0] baud_div = 16'h0003;
  utde_cfg_s cfg = 5'h10;
  utde_irq_s irq;
  int n_mismatch = 0, checks_done = 0, n_tx = 0, n_rx = 0, n_tim = 0, lead, frames, t;
  logic [7:0] q[$];
  utde_row_s rows [5] = '{'{8'hA5, 5'h10}, '{8'h3C, 5'h18}, '{8'h81, 5'h1D},
    '{8'h00, 5'h13}, '{8'hFF, 5'h1E}};
  utde_tx dut (.CLK(clk), .RESET(reset), .CFG(cfg), .BAUD_DIV(baud_div), .TX_DATA(tx_data),
    .TX_WRITE(tx_write), .TX_READY(tx_ready), .RX_EVENT(rx_event), .TXD(txd),
    .TRANSCEIVER_DRIVE_GATE(gate), .IRQ(irq));
  utde_line_model model (.clk(clk), .cfg(cfg), .baud_div(baud_div), .txd(txd),
    .transceiver_drive_gate(gate), .bus(bus), .rx_byte(rx_byte), .rx_bad(rx_bad),
    .lead(lead), .end_act(end_act), .rel_act(rel_act), .frames(frames));
  // clock and interrupt pulse counters
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    n_tx <= n_tx + (irq.tx_irq === 1'b1);
    n_rx <= n_rx + (irq.rx_irq === 1'b1);
    n_tim <= n_tim + (irq.timer_irq === 1'b1);
  end
  task give_verdict;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task put(input logic [7:0] d);
    tx_data = d;
    tx_write = 1;
    @(negedge clk);
    tx_write = 0;
  endtask
  task wait_frame(input int f);
    for (int k = 0; k < 400 && frames < f; k++) @(negedge clk);
    `CHK(frames, f)
  endtask
  // watchdog cuts a hang short
  initial begin
    #50000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (4) @(negedge clk);
    `CHK({txd, gate, irq, tx_ready}, 6'h21)
    @(negedge clk);
    reset = 0;
    // table of single frames under five formats (no 8E2) and both polarities
    foreach (rows[i]) begin
      cfg = rows[i].cfg;
      repeat (3) @(negedge clk);
      `CHK(gate, cfg.driver_enable_polarity)
      t = n_tx;
      put(rows[i].data);
      `CHK(gate, cfg.driver_enable_polarity)
      repeat (2) @(negedge clk);
      `CHK(gate, ~cfg.driver_enable_polarity)
      wait_frame(i + 1);
      `CHK({rx_bad, rx_byte}, {1'b0, rows[i].data})
      `CHK(lead >= 4 && lead <= 8, 1'b1)
      `CHK({end_act, rel_act}, 2'h2)
      `CHK(n_tx, t + 1)
    end
    // back to back writes until the fifo refuses, then drain
    cfg = 5'h10;
    t = frames;
    for (int k = 0; k < 6; k++) begin
      tx_data = 8'h11 * k + 8'h0F;
      tx_write = 1;
      if (tx_ready) q.push_back(tx_data);
      @(negedge clk);
    end
    tx_write = 0;
    `CHK(q.size(), 5)
    foreach (q[j]) begin
      wait_frame(t + j + 1);
      `CHK(rx_byte, q[j])
      if (j > 0) `CHK(lead, 0)
    end
    `CHK(tx_ready, 1'b1)
    // receive event raises only the receive request
    t = n_tx;
    rx_event = 1;
    @(negedge clk);
    rx_event = 0;
    repeat (6) @(negedge clk);
    `CHK({n_rx, n_tx}, {32'd1, t})
    // disable mid-frame: gate drops, generator ticks as a timer
    `CHK(n_tim, 0)
    put(8'h5A);
    repeat (10) @(negedge clk);
    cfg = 5'h00;
    repeat (3) @(negedge clk);
    `CHK(gate, 1'b0)
    t = n_tim;
    repeat (40) @(negedge clk);
    `CHK(n_tim - t >= 9 && n_tim - t <= 11, 1'b1)
    // reset in mid-frame returns the gate to its inactive level
    cfg = 5'h11;
    put(8'hC3);
    repeat (8) @(negedge clk);
    `CHK(gate, 1'b0)
    reset = 1;
    @(negedge clk);
    `CHK({txd, gate, irq, tx_ready}, 6'h31)
    repeat (4) @(negedge clk);
    reset = 0;
    repeat (3) @(negedge clk);
    `CHK({txd, gate, tx_ready}, 3'h7)
    give_verdict;
  end
endmodule
